// ===== rtl/ldo_seq_cfg.svh
`ifndef LDO_SEQ_CFG_SVH
`define LDO_SEQ_CFG_SVH
// ----------------------------------------
// Register offsets
// ----------------------------------------
`define OFF_GOOD_MASK_MAIN 8'h1C
`define OFF_ENABLE_SOURCE_SELECT 8'h1D
`define OFF_EDGE_DELAY_CONFIG 8'h1E
// ----------------------------------------
// Field positions
// ----------------------------------------
`define SRC_LSB 2
`define SRC_MSB 4
`define RISE_LSB 0
`define RISE_MSB 2
`define FALL_LSB 3
`define FALL_MSB 5
`define OFFT_LSB 6
`define OFFT_MSB 7
`define MASK_COMBINED_BIT 1
`define MASK_SWITCH_B1_BIT 0
// ----------------------------------------
// Timing
// ----------------------------------------
`define CLK_HZ 25000000
`define MS_NS 1000000
`define CLK_NS 40
`define CYCLES_PER_MS (`MS_NS / `CLK_NS)
`define DLY_MS_0 32'd0
`define DLY_MS_1 32'd2
`define DLY_MS_2 32'd4
`define DLY_MS_3 32'd8
`define DLY_MS_4 32'd16
`define DLY_MS_5 32'd24
`define DLY_MS_6 32'd32
`define DLY_MS_7 32'd64
`define OFFT_MS_0 32'd1
`define OFFT_MS_1 32'd5
`define OFFT_MS_2 32'd10
`define OFFT_MS_3 32'd100
`endif

// ===== rtl/ldo_seq_pkg.sv
package ldo_seq_pkg;
  typedef enum logic [1:0] {ST_OFF, ST_RISE_WAIT, ST_ON, ST_FALL_WAIT} seq_state_t;
endpackage

// ===== rtl/ldo_rail_enable_sequencer.sv
`timescale 1ns/10ps
`include "ldo_seq_cfg.svh"
module ldo_rail_enable_sequencer (
  input wire logic clk, // 25 MHz clock
  input wire logic rst_n, // Synchronous reset
  input wire logic reg_wr, // Register write strobe
  input wire logic [7:0] reg_addr, // Register offset
  input wire logic [7:0] reg_wdata, // Write data
  output logic [7:0] reg_rdata, // Read data
  input wire logic [7:0] otp_mask_main, // Default for mask register
  input wire logic [7:0] otp_source_select, // Default for source register
  input wire logic [7:0] otp_edge_delay, // Default for delay register
  input wire logic [5:0] converter_power_good, // Converters six..one goods
  input wire logic first_switch_rail_power_good, // First switch good
  input wire logic third_ldo_rail_power_good, // Third LDO good
  input wire logic combined_switch_ldo_rail_power_good, // Combined rail good
  input wire logic second_switch_b_rail_power_good, // Switch B1 good
  input wire logic control_pin_one, // Control pin 1
  input wire logic control_pin_two, // Control pin 2
  input wire logic control_pin_three, // Control pin 3
  input wire logic control_pin_four, // Control pin 4
  input wire logic control_pin_five, // Control pin 5
  input wire logic control_pin_six, // Control pin 6
  output logic target_ldo_rail_enable, // Delayed rail enable
  output logic [1:0] shutdown_off_time_field, // Off time code for first LDO
  output logic [31:0] shutdown_off_time_cycles // Off time in clock cycles
);
  // ----------------------------------------
  // Registers
  // ----------------------------------------
  logic [7:0] mask_main_reg;
  logic [7:0] src_sel_reg;
  logic [7:0] delay_reg;
  ldo_seq_pkg::seq_state_t state_reg, state_next;
  logic [31:0] cnt_reg, cnt_next;
  logic en_reg;

  // ----------------------------------------
  // Register decode
  // ----------------------------------------
  wire sel_main = reg_addr == `OFF_GOOD_MASK_MAIN;
  wire sel_src = reg_addr == `OFF_ENABLE_SOURCE_SELECT;
  wire sel_dly = reg_addr == `OFF_EDGE_DELAY_CONFIG;
  wire wr_main = reg_wr & sel_main;
  wire wr_src = reg_wr & sel_src;
  wire wr_dly = reg_wr & sel_dly;

  // Reset loads the one-time-programmable defaults, sampled on the clock edge.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      mask_main_reg <= otp_mask_main;
    end else if (wr_main) begin
      mask_main_reg <= reg_wdata;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      src_sel_reg <= otp_source_select;
    end else if (wr_src) begin
      src_sel_reg <= reg_wdata;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      delay_reg <= otp_edge_delay;
    end else if (wr_dly) begin
      delay_reg <= reg_wdata;
    end
  end

  // Unmapped offsets read as zero so a stray read never aliases a live register.
  assign reg_rdata = sel_main ? mask_main_reg : sel_src ? src_sel_reg :
                     sel_dly ? delay_reg : 8'h00;

  // ----------------------------------------
  // Enable condition
  // ----------------------------------------
  wire [7:0] main_goods = {third_ldo_rail_power_good, first_switch_rail_power_good,
                           converter_power_good};
  wire [7:0] main_included = main_goods | mask_main_reg;
  wire main_ok = &main_included;
  wire combined_rail_good_mask = src_sel_reg[`MASK_COMBINED_BIT];
  wire switch_b1_good_mask = src_sel_reg[`MASK_SWITCH_B1_BIT];
  wire second_ok = (combined_switch_ldo_rail_power_good | combined_rail_good_mask) &
                   (second_switch_b_rail_power_good | switch_b1_good_mask);
  wire [2:0] enable_source_field = src_sel_reg[`SRC_MSB:`SRC_LSB];
  logic source_on;
  always_comb begin
    case (enable_source_field)
      3'h0: source_on = control_pin_one;
      3'h1: source_on = control_pin_two;
      3'h2: source_on = control_pin_five;
      3'h3: source_on = control_pin_four;
      3'h4: source_on = control_pin_three;
      3'h5: source_on = control_pin_three & control_pin_four;
      3'h6: source_on = control_pin_six;
      default: source_on = 1'b1;
    endcase
  end
  wire enable_req = source_on & main_ok & second_ok;

  // ----------------------------------------
  // Edge delays
  // ----------------------------------------
  wire [2:0] rise_delay_field = delay_reg[`RISE_MSB:`RISE_LSB];
  wire [2:0] fall_delay_field = delay_reg[`FALL_MSB:`FALL_LSB];
  logic [31:0] rise_cycles;
  logic [31:0] fall_cycles;

  // Rise and fall share one decoder table, so the two edges cannot drift apart.
  delay_code_decoder #(
    .CODE_W(3)
  ) rise_decoder_inst (
    .code(rise_delay_field),
    .cycles(rise_cycles)
  );
  delay_code_decoder #(
    .CODE_W(3)
  ) fall_decoder_inst (
    .code(fall_delay_field),
    .cycles(fall_cycles)
  );

  // ----------------------------------------
  // Sequencer
  // ----------------------------------------
  // A request that drops during the rise delay, or returns during the fall delay, abandons that delay,
  // so glitches on the pin do not toggle the rail.
  always_comb begin
    state_next = state_reg;
    cnt_next = cnt_reg;
    case (state_reg)
      ldo_seq_pkg::ST_OFF: begin
        if (enable_req) begin
          state_next = ldo_seq_pkg::ST_RISE_WAIT;
          cnt_next = 32'd0;
        end
      end
      ldo_seq_pkg::ST_RISE_WAIT: begin
        if (!enable_req) state_next = ldo_seq_pkg::ST_OFF;
        else if (cnt_reg >= rise_cycles) state_next = ldo_seq_pkg::ST_ON;
        else cnt_next = cnt_reg + 32'd1;
      end
      ldo_seq_pkg::ST_ON: begin
        if (!enable_req) begin
          state_next = ldo_seq_pkg::ST_FALL_WAIT;
          cnt_next = 32'd0;
        end
      end
      ldo_seq_pkg::ST_FALL_WAIT: begin
        if (enable_req) state_next = ldo_seq_pkg::ST_ON;
        else if (cnt_reg >= fall_cycles) state_next = ldo_seq_pkg::ST_OFF;
        else cnt_next = cnt_reg + 32'd1;
      end
      default: state_next = ldo_seq_pkg::ST_OFF;
    endcase
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state_reg <= ldo_seq_pkg::ST_OFF;
      cnt_reg <= 32'd0;
      en_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      cnt_reg <= cnt_next;
      en_reg <= (state_next == ldo_seq_pkg::ST_ON) ||
                (state_next == ldo_seq_pkg::ST_FALL_WAIT);
    end
  end
  assign target_ldo_rail_enable = en_reg;

  // ----------------------------------------
  // Shutdown off time
  // ----------------------------------------
  // The off time is only exported; the shutdown sequencer that times it sits elsewhere.
  assign shutdown_off_time_field = delay_reg[`OFFT_MSB:`OFFT_LSB];
  always_comb begin
    case (shutdown_off_time_field)
      2'h0: shutdown_off_time_cycles = `OFFT_MS_0 * `CYCLES_PER_MS;
      2'h1: shutdown_off_time_cycles = `OFFT_MS_1 * `CYCLES_PER_MS;
      2'h2: shutdown_off_time_cycles = `OFFT_MS_2 * `CYCLES_PER_MS;
      default: shutdown_off_time_cycles = `OFFT_MS_3 * `CYCLES_PER_MS;
    endcase
  end
endmodule // ldo_rail_enable_sequencer

// ----------------------------------------
// Delay code decoder
// ----------------------------------------
module delay_code_decoder #(
  parameter int CODE_W = 3 // Width of a delay code
) (
  input wire logic [CODE_W-1:0] code, // Delay code from the register
  output logic [31:0] cycles // Delay length in clock cycles
);
  logic [31:0] ms;

  // A 32-bit product covers the longest delay of 64 ms with room to spare.
  always_comb begin
    case (code)
      3'h0: ms = `DLY_MS_0;
      3'h1: ms = `DLY_MS_1;
      3'h2: ms = `DLY_MS_2;
      3'h3: ms = `DLY_MS_3;
      3'h4: ms = `DLY_MS_4;
      3'h5: ms = `DLY_MS_5;
      3'h6: ms = `DLY_MS_6;
      default: ms = `DLY_MS_7;
    endcase
    cycles = ms * `CYCLES_PER_MS;
  end
endmodule // delay_code_decoder

// ===== tb/ldo_rail_enable_sequencer_monitor.sv
`timescale 1ns/10ps
module ldo_rail_enable_sequencer_monitor (
  input wire logic clk, // clock
  input wire logic rst_n, // reset
  input wire logic reg_wr, // write
  input wire logic [7:0] reg_addr, // offset
  input wire logic [7:0] reg_wdata, // data in
  input wire logic [7:0] reg_rdata, // data out
  input wire logic [1:0] shutdown_off_time_field, // code
  input wire logic [31:0] shutdown_off_time_cycles // length
);
  int lt [4] = '{25000, 125000, 250000, 2500000};
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  mask_back_a: assert property (reg_wr && reg_addr == 8'h1C ##1 reg_addr == 8'h1C
    |-> reg_rdata == $past(reg_wdata)) else $error("mask readback");
  src_back_a: assert property (reg_wr && reg_addr == 8'h1D ##1 reg_addr == 8'h1D
    |-> reg_rdata == $past(reg_wdata)) else $error("source readback");
  delay_back_a: assert property (reg_wr && reg_addr == 8'h1E ##1 reg_addr == 8'h1E
    |-> reg_rdata == $past(reg_wdata)) else $error("delay readback");
  hole_zero_a: assert property (!(reg_addr inside {8'h1C, 8'h1D, 8'h1E})
    |-> reg_rdata == 8'h00) else $error("unmapped read");
  off_code_a: assert property (reg_wr && reg_addr == 8'h1E
    |=> shutdown_off_time_field == $past(reg_wdata[7:6])) else $error("off code");
  off_len_a: assert property (shutdown_off_time_cycles == 32'(lt[shutdown_off_time_field]))
    else $error("off length");
  off_hold_a: assert property (!$past(reg_wr) |-> $stable(shutdown_off_time_field))
    else $error("off drift");
  read_hold_a: assert property (!$past(reg_wr) && $stable(reg_addr) |-> $stable(reg_rdata))
    else $error("read drift");
endmodule // ldo_rail_enable_sequencer_monitor

// ===== tb/rail_partner.sv
`timescale 1ns/10ps
module rail_partner (
  input wire logic clk, // clock
  input wire logic [5:0] pin_want, // pin levels
  input wire logic [9:0] good_want, // good levels
  output logic [5:0] pins = 6'h00, // pins six..one
  output logic [9:0] goods = 10'h3FF // rail goods
);
  // Levels move on the falling edge, a cycle late, like a slow outside party.
  always @(negedge clk) begin
    pins <= pin_want;
    goods <= good_want;
  end
endmodule // rail_partner

// ===== tb/test_ldo_rail_enable_sequencer.sv
`timescale 1ns/10ps
`define CHK(g, e) begin comparisons++; \
  if ((g) !== (e)) begin errors++; $display("mismatch at %0t: bad value", $time); end end
bind ldo_rail_enable_sequencer ldo_rail_enable_sequencer_monitor monitor_inst (.*);
module test_ldo_rail_enable_sequencer;
  logic clk = 0, rst_n = 0, reg_wr = 0;
  logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata;
  logic [7:0] otp_mask_main = 8'hA5, otp_source_select = 8'h5A, otp_edge_delay = 8'h3C;
  logic [5:0] pin_want = 6'h00, pins, converter_power_good;
  logic [9:0] good_want = 10'h3FF, goods, m;
  logic control_pin_one, control_pin_two, control_pin_three;
  logic control_pin_four, control_pin_five, control_pin_six;
  logic first_switch_rail_power_good, third_ldo_rail_power_good;
  logic combined_switch_ldo_rail_power_good, second_switch_b_rail_power_good;
  logic target_ldo_rail_enable;
  logic [1:0] shutdown_off_time_field;
  logic [31:0] shutdown_off_time_cycles;
  int errors = 0, comparisons = 0;
  int lt [4] = '{25000, 125000, 250000, 2500000};
  logic [5:0] st [8] = '{6'h01, 6'h02, 6'h10, 6'h08, 6'h04, 6'h0C, 6'h20, 6'h00};
  assign {control_pin_six, control_pin_five, control_pin_four, control_pin_three,
    control_pin_two, control_pin_one} = pins;
  assign {combined_switch_ldo_rail_power_good, second_switch_b_rail_power_good,
    third_ldo_rail_power_good, first_switch_rail_power_good, converter_power_good} = goods;
  ldo_rail_enable_sequencer ldo_rail_enable_sequencer_inst (.*);
  rail_partner rail_partner_inst (.clk(clk), .pin_want(pin_want), .good_want(good_want),
    .pins(pins), .goods(goods));
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk) reg_wr = 1;
    reg_addr = a;
    reg_wdata = d;
    @(negedge clk) reg_wr = 0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(negedge clk) reg_addr = a;
    #1 `CHK(reg_rdata, e)
  endtask
  task automatic wait_en(input int n, input logic e);
    repeat (n) @(negedge clk);
    `CHK(target_ldo_rail_enable, e)
  endtask
  task automatic end_of_test;
    $display("comparisons %0d errors %0d", comparisons, errors);
    if (errors == 0 && comparisons > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  initial begin
    forever #20 clk = ~clk;
  end
  initial begin
    #4400000;
    errors++;
    end_of_test();
  end
  initial begin
    repeat (3) @(negedge clk);
    rst_n = 1;
    rd(8'h1C, 8'hA5);
    rd(8'h1D, 8'h5A);
    rd(8'h1E, 8'h3C);
    rd(8'h1F, 8'h00);
    $display("reset test done");
    wr(8'h1C, 8'hFF);
    wr(8'h1E, 8'h00);
    for (int c = 0; c < 8; c++) begin
      wr(8'h1D, {3'h0, c[2:0], 2'h3});
      pin_want <= ~st[c];
      wait_en(5, c == 7);
      pin_want <= st[c];
      wait_en(5, 1'b1);
    end
    $display("source test done");
    for (int i = 0; i < 10; i++) begin
      m = ~(10'h001 << i);
      good_want <= m;
      wr(8'h1C, m[7:0]);
      wr(8'h1D, {6'h07, m[9:8]});
      wait_en(5, 1'b0);
      wr(8'h1C, 8'hFF);
      wr(8'h1D, 8'h1F);
      wait_en(5, 1'b1);
    end
    $display("mask test done");
    for (int f = 0; f < 4; f++) begin
      wr(8'h1E, {f[1:0], 6'h00});
      `CHK(shutdown_off_time_field, f[1:0])
      `CHK(shutdown_off_time_cycles, 32'(lt[f]))
    end
    $display("off time test done");
    good_want <= 10'h3FF;
    wr(8'h1E, 8'h01);
    wr(8'h1D, 8'h03);
    wait_en(5, 1'b0);
    pin_want <= 6'h01;
    wait_en(49990, 1'b0);
    wait_en(20, 1'b1);
    wr(8'h1E, 8'h08);
    pin_want <= 6'h00;
    wait_en(49990, 1'b1);
    wait_en(20, 1'b0);
    $display("delay test done");
    end_of_test();
  end
endmodule // test_ldo_rail_enable_sequencer
